// File: sids_core.sv
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// What this block does
// - store IN byte per matching microframe slot
// - new byte overwrites the old slot content
// - slots 3..6 in dw6, 0..2 high dw5
// - complete-split mask bits 39..32 select microframes
// - issue splits where mask bits are set; complete splits in IN direction only
// - three-bit result per microframe, dw4 10..8 up
// - result bits: error, babble, underrun
// - start mask acts only on frame match
// - summary babble is OR of result bit1
// - summary error is OR of result bit0
module sids_core
   import sids_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // link side
   input wire sids_bus_time_t bus_time,
   input wire sids_link_evt_t link_evt,
   output sids_issue_t issue,
   // interrupt
   output logic irq
);
   // ------------------------------------------------------------
   // descriptor state
   // ------------------------------------------------------------
   logic [7:0] ctrl, next_ctrl;           // dir + frame number
   logic [7:0] ss_mask, next_ss_mask;     // start-split mask
   logic [7:0] cs_mask, next_cs_mask;     // complete-split mask
   logic [7:0] slot [8];                  // in byte slots
   logic [7:0] next_slot [8];
   logic [2:0] result [8];                // per microframe result
   logic [2:0] next_result [8];
   logic [SIDS_NUM_EVENTS-1:0] irq_stat, next_irq_stat; // sticky events
   logic [SIDS_NUM_EVENTS-1:0] irq_en, next_irq_en;     // enables
   // ------------------------------------------------------------
   // bus pipeline
   // ------------------------------------------------------------
   logic wr_pend, next_wr_pend;         // write data phase pending
   logic [7:0] wr_addr, next_wr_addr;   // latched write offset
   logic [31:0] next_hrdata;            // read data for data phase
   logic addr_ok;                       // address phase accepted
   sids_issue_t next_issue;             // next split to issue
   logic babble_sum, err_sum;           // summaries
   logic frame_match;                   // descriptor frame equals bus frame
   logic next_irq;                      // level for the irq flop
   logic [31:0] dw4, dw5, dw6, dw7;     // packed descriptor words

   // an address phase counts only when the bus is ready and the slot is active
   assign addr_ok = hsel & hready & htrans[1];

   // ------------------------------------------------------------
   // descriptor word packing
   // ------------------------------------------------------------
   always_comb
   begin
      dw4 = {24'h000000, ss_mask};
      for (int i = 0; i < 8; i++)
      begin
         dw4[SIDS_RESULT_LSB + SIDS_RESULT_W*i +: SIDS_RESULT_W] = result[i];
      end
      // slots 0..2 above the cs mask, slots 3..6 fill dw6
      dw5 = {slot[2], slot[1], slot[0], cs_mask};
      dw6 = {slot[6], slot[5], slot[4], slot[3]};
      dw7 = {24'h000000, slot[7]};
      babble_sum = 1'b0;
      err_sum = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         babble_sum = babble_sum | result[i][SIDS_RES_BABBLE];
         err_sum = err_sum | result[i][SIDS_RES_XACT_ERR];
      end
   end

   // five-bit frame compare; a stale frame keeps the start mask idle
   assign frame_match = (ctrl[7:SIDS_CTRL_FRAME_LSB] == bus_time.frame);

   // ------------------------------------------------------------
   // next-state for descriptor, irq and bus
   // ------------------------------------------------------------
   // one process for all next values keeps the priority order visible
   always_comb
   begin
      logic [7:0] wmask;
      logic [2:0] u;
      wmask = 8'h00;
      u = link_evt.uframe;
      next_ctrl = ctrl;
      next_ss_mask = ss_mask;
      next_cs_mask = cs_mask;
      next_slot = slot;
      next_result = result;
      next_irq_en = irq_en;
      next_irq_stat = irq_stat;
      next_wr_pend = addr_ok & hwrite;
      next_wr_addr = addr_ok ? haddr[7:0] : wr_addr;
      next_hrdata = 32'h0000_0000;
      next_issue = '0;
      // software writes first; hardware events below win
      if (wr_pend)
      begin
         if (wr_addr == SIDS_OFF_CTRL)
         begin
            next_ctrl = hwdata[7:0];
         end
         else if (wr_addr == SIDS_OFF_DW4)
         begin
            // software only sets; in direction masks micro 4..7
            wmask = hwdata[7:0];
            if (ctrl[SIDS_CTRL_DIR_IN])
            begin
               wmask = wmask & 8'h0F;
            end
            next_ss_mask = ss_mask | wmask;
         end
         else if (wr_addr == SIDS_OFF_DW5)
         begin
            // any set of bits allowed, in only
            if (ctrl[SIDS_CTRL_DIR_IN])
            begin
               next_cs_mask = cs_mask | hwdata[7:0];
            end
         end
         else if (wr_addr == SIDS_OFF_IRQ_CLR)
         begin
            next_irq_stat = irq_stat & ~hwdata[SIDS_NUM_EVENTS-1:0];
         end
         else if (wr_addr == SIDS_OFF_IRQ_EN)
         begin
            next_irq_en = hwdata[SIDS_NUM_EVENTS-1:0];
         end
      end
      // issue on each microframe start
      if (bus_time.sof)
      begin
         next_issue.uframe = bus_time.uframe;
         next_issue.ss = ss_mask[bus_time.uframe] & frame_match;
         next_issue.cs = cs_mask[bus_time.uframe] & ctrl[SIDS_CTRL_DIR_IN];
      end
      // hardware events come last so a same-cycle clear loses
      // link completions
      if (link_evt.valid)
      begin
         next_result[u] = link_evt.result;
         if (link_evt.is_cs)
         begin
            next_cs_mask[u] = 1'b0;
            next_irq_stat[1] = 1'b1;
         end
         else
         begin
            next_ss_mask[u] = 1'b0;
            next_irq_stat[0] = 1'b1;
         end
         // byte lands only in armed, frame-matched slot; overwrite
         if (link_evt.has_data && ss_mask[u] && frame_match)
         begin
            next_slot[u] = link_evt.data;
         end
         if (link_evt.result[SIDS_RES_BABBLE])
         begin
            next_irq_stat[2] = 1'b1;
         end
         if (link_evt.result[SIDS_RES_XACT_ERR])
         begin
            next_irq_stat[3] = 1'b1;
         end
      end
      // level interrupt from the values about to be registered, so irq
      // follows the status bit at the same edge without a lag cycle
      next_irq = |(next_irq_stat & next_irq_en);
      // read decode
      // registered into hrdata, so the data phase sees a settled value
      if (addr_ok && !hwrite)
      begin
         if (haddr[7:0] == SIDS_OFF_CTRL)
         begin
            next_hrdata = {24'h000000, ctrl};
         end
         else if (haddr[7:0] == SIDS_OFF_DW4)
         begin
            next_hrdata = dw4;
         end
         else if (haddr[7:0] == SIDS_OFF_DW5)
         begin
            next_hrdata = dw5;
         end
         else if (haddr[7:0] == SIDS_OFF_DW6)
         begin
            next_hrdata = dw6;
         end
         else if (haddr[7:0] == SIDS_OFF_DW7)
         begin
            next_hrdata = dw7;
         end
         else if (haddr[7:0] == SIDS_OFF_IRQ_STAT)
         begin
            next_hrdata = {28'h0000000, irq_stat};
         end
         else if (haddr[7:0] == SIDS_OFF_IRQ_EN)
         begin
            next_hrdata = {28'h0000000, irq_en};
         end
         else if (haddr[7:0] == SIDS_OFF_SUMMARY)
         begin
            next_hrdata = {30'h0, babble_sum, err_sum};
         end
         else
         begin
            next_hrdata = 32'h0000_0000; // unmapped reads zero
         end
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= 8'h00;
         ss_mask <= 8'h00;
         cs_mask <= 8'h00;
         for (int i = 0; i < 8; i++)
         begin
            slot[i] <= 8'h00;
            result[i] <= 3'h0;
         end
         irq_stat <= 4'h0;
         irq_en <= 4'h0;
         issue <= '0;
         irq <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         ss_mask <= next_ss_mask;
         cs_mask <= next_cs_mask;
         slot <= next_slot;
         result <= next_result;
         irq_stat <= next_irq_stat;
         irq_en <= next_irq_en;
         issue <= next_issue;
         irq <= next_irq;
      end
   end

   // ------------------------------------------------------------
   // bus pipeline registers
   // ------------------------------------------------------------
   // the write is held one cycle so hwdata can be taken in its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend <= 1'b0;           // no write in flight after reset
         wr_addr <= 8'h00;
         hrdata <= SIDS_RESET_WORD; // bus reads zero until a read phase
      end
      else
      begin
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;     // stands for the one data phase only
      end
   end

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   // zero-wait slave, always okay; no wait state is ever needed because
   // every register answers from state already held in flip-flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule : sids_core

// File: sids_core_properties.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checker for the split descriptor block
// ------------------------------------------------------------
module sids_core_properties
   import sids_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus side
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // link side
   input wire sids_bus_time_t bus_time,
   input wire sids_link_evt_t link_evt,
   input wire sids_issue_t issue,
   input wire logic irq
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // accepted address phases
   wire logic rd_addr = hsel && hready && htrans[1] && !hwrite;
   wire logic wr_addr = hsel && hready && htrans[1] && hwrite;
   // one microframe start, then a quiet cycle
   sequence s_sof_once;
      bus_time.sof ##1 !bus_time.sof;
   endsequence
   a_ready_always: assert property (hreadyout) else $error("slave stalled the bus");
   a_resp_okay: assert property (!hresp) else $error("slave answered with an error");
   a_rdata_idle: assert property (!rd_addr |=> hrdata == 32'h0000_0000)
      else $error("read data outside a read data phase");
   a_issue_after_sof: assert property ((issue.ss || issue.cs) |-> $past(bus_time.sof))
      else $error("split issued without a microframe start");
   a_issue_uframe: assert property ((issue.ss || issue.cs) |->
      issue.uframe == $past(bus_time.uframe)) else $error("split issued in wrong microframe");
   a_issue_pulse: assert property (s_sof_once |=> !issue.ss && !issue.cs)
      else $error("split issue lasted more than one cycle");
   // irq only moves after a link event or a register write
   a_irq_rise: assert property ($rose(irq) |-> $past(link_evt.valid, 1) ||
      $past(link_evt.valid, 2) || $past(wr_addr, 2) || $past(wr_addr, 3))
      else $error("interrupt rose without a cause");
   a_irq_fall: assert property ($fell(irq) |-> $past(wr_addr, 1) || $past(wr_addr, 2) ||
      $past(wr_addr, 3)) else $error("interrupt fell without a write");
endmodule : sids_core_properties

bind sids_core sids_core_properties u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .bus_time(bus_time), .link_evt(link_evt),
   .issue(issue), .irq(irq));

// File: sids_link_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// far-side model: answers each issued split with a link event
// ------------------------------------------------------------
module sids_link_model
   import sids_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // splits from the block
   input wire sids_issue_t issue,
   // scenario controls
   input wire logic [2:0] res_val,
   input wire logic [7:0] data_base,
   // answers to the block
   output sids_link_evt_t link_evt
);
   sids_issue_t pend; // splits still owed an answer
   int wait_cnt; // odd microframes answer slowly
   // start split answers first, carrying the IN byte
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         link_evt <= '0;
         pend <= '0;
         wait_cnt <= 0;
      end
      else if (issue.ss || issue.cs)
      begin
         link_evt.valid <= 1'b0;
         pend <= issue;
         wait_cnt <= issue.uframe[0] ? 4 : 1;
      end
      else if ((pend.ss || pend.cs) && wait_cnt > 1)
      begin
         link_evt.valid <= 1'b0;
         wait_cnt <= wait_cnt - 1;
      end
      else if (pend.ss || pend.cs)
      begin
         // result bits: error, babble, underrun
         link_evt <= '{valid: 1'b1, uframe: pend.uframe, is_cs: !pend.ss, has_data: pend.ss,
            data: data_base + 8'(pend.uframe), result: res_val};
         pend.ss <= 1'b0;
         pend.cs <= pend.ss ? pend.cs : 1'b0;
         wait_cnt <= 1;
      end
      else
      begin
         // no stale byte while idle: data toggles every cycle
         link_evt.valid <= 1'b0;
         link_evt.data <= ~link_evt.data;
      end
   end
endmodule : sids_link_model

// File: sids_pkg.sv
package sids_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] SIDS_OFF_CTRL = 8'h00;    // direction, frame number
   localparam logic [7:0] SIDS_OFF_DW4 = 8'h04;     // results + start mask
   localparam logic [7:0] SIDS_OFF_DW5 = 8'h08;     // slots 0..2 + cs mask
   localparam logic [7:0] SIDS_OFF_DW6 = 8'h0C;     // slots 3..6
   localparam logic [7:0] SIDS_OFF_DW7 = 8'h10;     // slot 7
   localparam logic [7:0] SIDS_OFF_IRQ_STAT = 8'h14; // sticky events, read only
   localparam logic [7:0] SIDS_OFF_IRQ_CLR = 8'h18;  // write one to clear
   localparam logic [7:0] SIDS_OFF_IRQ_EN = 8'h1C;   // enables
   localparam logic [7:0] SIDS_OFF_SUMMARY = 8'h20;  // babble/error summary
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int SIDS_CS_MASK_LSB = 0;      // dw5 bits 7..0 (39..32 of pair)
   localparam int SIDS_SLOT0_LSB = 8;        // dw5 bits 15..8 (47..40 of pair)
   localparam int SIDS_RESULT_LSB = 8;       // dw4 result 0 at 10..8
   localparam int SIDS_RESULT_W = 3;         // result width
   localparam int SIDS_CTRL_FRAME_LSB = 3;   // ctrl bits 7..3 frame number
   localparam int SIDS_CTRL_DIR_IN = 0;      // ctrl bit 0: 1 = IN
   localparam int SIDS_RES_XACT_ERR = 0;     // result bit 0
   localparam int SIDS_RES_BABBLE = 1;       // result bit 1
   localparam int SIDS_RES_UNDERRUN = 2;     // result bit 2
   // ------------------------------------------------------------
   // reset values and events
   // ------------------------------------------------------------
   localparam logic [31:0] SIDS_RESET_WORD = 32'h0000_0000; // all state cleared
   localparam int SIDS_NUM_EVENTS = 4; // ss done, cs done, babble, error
   localparam int SIDS_DATA_W = 32;   // bus data width
   // event from the link side: which microframe and what happened
   typedef struct packed
   {
      logic valid;        // one-cycle strobe
      logic [2:0] uframe; // microframe 0..7
      logic is_cs;        // 1 = complete split done, 0 = start split done
      logic has_data;     // an IN byte arrived
      logic [7:0] data;   // received byte
      logic [2:0] result; // error, babble, underrun
   } sids_link_evt_t;
   // tick from the bus timer
   typedef struct packed
   {
      logic sof;          // one-cycle microframe start
      logic [4:0] frame;  // current bus frame number
      logic [2:0] uframe; // current microframe
   } sids_bus_time_t;
   // split to issue this microframe
   typedef struct packed
   {
      logic ss;           // issue start split
      logic cs;           // issue complete split
      logic [2:0] uframe; // microframe of issue
   } sids_issue_t;
endpackage : sids_pkg

// File: tb_split_interrupt_descriptor_status.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// self-checking bench
// ------------------------------------------------------------
module tb_split_interrupt_descriptor_status
   import sids_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, res_val;
   logic [7:0] data_base;
   sids_bus_time_t bus_time;
   sids_link_evt_t link_evt;
   sids_issue_t issue;
   int mismatches = 0;
   int cmp_count = 0;
   int ss_cnt = 0;
   int cs_cnt = 0;
   assign hready = hreadyout; // single slave drives the bus ready
   sids_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .bus_time(bus_time),
      .link_evt(link_evt), .issue(issue), .irq(irq));
   sids_link_model u_link (.hclk(hclk), .hresetn(hresetn), .issue(issue), .res_val(res_val),
      .data_base(data_base), .link_evt(link_evt));
   // clock of 100 ns
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   // count issued splits
   always @(posedge hclk)
   begin
      if (issue.ss === 1'b1) ss_cnt++;
      if (issue.cs === 1'b1) cs_cnt++;
   end
   task automatic print_verdict();
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk
   // wait for ready sampled high, bounded
   task automatic wait_ready();
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1)
      begin
         mismatches++;
         print_verdict();
      end
   endtask : wait_ready
   // one single-word transfer
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      xfer(1'b1, a, d, rd);
   endtask : wr
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      xfer(1'b0, a, 32'h0000_0000, rd);
      chk(exp, rd);
   endtask : chk_rd
   // irq looked at mid-cycle, once settled
   task automatic chk_irq(input logic exp);
      @(negedge hclk);
      chk({31'h0000_0000, exp}, {31'h0000_0000, irq});
      @(posedge hclk);
   endtask : chk_irq
   // one microframe start, then room for the answers
   task automatic run_uf(input logic [4:0] f, input logic [2:0] u);
      bus_time <= '{sof: 1'b1, frame: f, uframe: u};
      @(posedge hclk);
      bus_time.sof <= 1'b0;
      repeat (12) @(posedge hclk);
   endtask : run_uf
   initial
   begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      bus_time = '0;
      res_val = 3'h0;
      data_base = 8'hA0;
      hresetn = 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      chk_rd(SIDS_OFF_DW4, 32'h0000_0000);
      chk_rd(8'h40, 32'h0000_0000);
      wr(SIDS_OFF_CTRL, 32'h0000_0029); // IN, frame 5
      wr(SIDS_OFF_IRQ_EN, 32'h0000_000F);
      wr(SIDS_OFF_DW4, 32'h0000_00FF);
      chk_rd(SIDS_OFF_DW4, 32'h0000_000F);
      wr(SIDS_OFF_DW5, 32'h0000_00FF);
      chk_rd(SIDS_OFF_DW5, 32'h0000_00FF);
      for (int u = 0; u < 8; u++) run_uf(5'h05, 3'(u));
      chk(32'h0000_0004, 32'(ss_cnt));
      chk(32'h0000_0008, 32'(cs_cnt));
      chk_rd(SIDS_OFF_DW4, 32'h0000_0000);
      chk_rd(SIDS_OFF_DW5, 32'hA2A1_A000);
      chk_rd(SIDS_OFF_DW6, 32'h0000_00A3);
      chk_rd(SIDS_OFF_DW7, 32'h0000_0000);
      // second pass: wrong frame, overwrite, last result field
      wr(SIDS_OFF_DW4, 32'h0000_0001);
      wr(SIDS_OFF_DW5, 32'h0000_0080);
      res_val <= 3'h3;
      data_base <= 8'h5B;
      run_uf(5'h06, 3'h0);
      chk_rd(SIDS_OFF_DW4, 32'h0000_0001);
      run_uf(5'h05, 3'h0);
      res_val <= 3'h4;
      run_uf(5'h05, 3'h7);
      chk_rd(SIDS_OFF_DW4, 32'h8000_0300);
      chk_rd(SIDS_OFF_DW5, 32'hA2A1_5B00);
      chk_rd(SIDS_OFF_SUMMARY, 32'h0000_0003);
      // out direction: upper start bits kept, complete-split writes dropped
      wr(SIDS_OFF_CTRL, 32'h0000_0028);
      wr(SIDS_OFF_DW4, 32'h0000_0010);
      chk_rd(SIDS_OFF_DW4, 32'h8000_0310);
      wr(SIDS_OFF_DW5, 32'h0000_0001);
      chk_rd(SIDS_OFF_DW5, 32'hA2A1_5B00);
      run_uf(5'h05, 3'h4);
      chk_rd(SIDS_OFF_DW6, 32'h0000_5FA3);
      chk_rd(SIDS_OFF_DW4, 32'h8040_0300);
      chk(32'h0000_0006, 32'(ss_cnt));
      // interrupt raise, mask, clear
      chk_rd(SIDS_OFF_IRQ_STAT, 32'h0000_000F);
      chk_irq(1'b1);
      wr(SIDS_OFF_IRQ_EN, 32'h0000_0000);
      chk_rd(SIDS_OFF_IRQ_EN, 32'h0000_0000);
      chk_irq(1'b0);
      wr(SIDS_OFF_IRQ_EN, 32'h0000_000F);
      wr(SIDS_OFF_IRQ_CLR, 32'h0000_000F);
      wr(SIDS_OFF_IRQ_STAT, 32'h0000_000F);
      chk_rd(SIDS_OFF_IRQ_STAT, 32'h0000_0000);
      chk_irq(1'b0);
      print_verdict();
   end
endmodule : tb_split_interrupt_descriptor_status
